// file: dsp_chain_model.sv
`timescale 1ns/1ps
module dsp_chain_model #(
	parameter int DLY = 20
) (
	// Clock and reset
	input logic	aclk,
	input logic	aresetn,
	// Chain control and status
	input logic	power_chain_en,
	output logic	power_chain_good
);
	int cnt;
	// Good drops with the enable at once, so a stale good cannot hide a wake
	assign power_chain_good = power_chain_en && cnt == DLY;
	always @(posedge aclk)
		if (!aresetn) cnt <= DLY;
		else if (!power_chain_en) cnt <= 0;
		else if (cnt != DLY) cnt <= cnt + 1;
endmodule // dsp_chain_model

// file: dsp_map.vh
`ifndef DSP_MAP_VH
`define DSP_MAP_VH

// Register byte offsets
`define DSP_OFF_CTRL      4'h0
`define DSP_OFF_WAKE      4'h4
`define DSP_OFF_STATUS    4'h8
`define DSP_OFF_CLOCKS    4'hC

// Control register fields
`define DSP_CTRL_SE       0
`define DSP_CTRL_SM_LO    1
`define DSP_CTRL_SM_HI    3
`define DSP_CTRL_AS2      4
`define DSP_CTRL_W        5
`define DSP_CTRL_RESET    5'h00

// Wake register: source enables [10:0], upper_external_irq_lines level [14:11]
`define DSP_WAKE_W        15
`define DSP_WAKE_RESET    15'h0000
`define DSP_LVL_LO        11
`define DSP_LVL_HI        14

// Wake source bit positions
`define DSP_SRC_INT_LO    0
`define DSP_SRC_INT_HI    3
`define DSP_SRC_UPPER_LO  4
`define DSP_SRC_UPPER_HI  7
`define DSP_SRC_PCINT     8
`define DSP_SRC_TWI       9
`define DSP_SRC_T2        10
`define DSP_SRC_SPM       11
`define DSP_SRC_ADC       12
`define DSP_SRC_WDT       13
`define DSP_SRC_OTHER     14
`define DSP_SRC_SYMCNT    15
`define DSP_SRC_TRX       16
`define DSP_SRC_W         17

// Sleep mode codes
`define DSP_SM_IDLE       3'h0
`define DSP_SM_ADCNR      3'h1
`define DSP_SM_PDOWN      3'h2
`define DSP_SM_PSAVE      3'h3
`define DSP_SM_STBY       3'h6
`define DSP_SM_XSTBY      3'h7

// Clock enable vector: cpu, flash, io, adc, asy, main osc, timer osc
`define DSP_CLK_W         7
`define DSP_CLK_ALL       7'h7F
`define DSP_CLK_CPU       0
`define DSP_CLK_FLASH     1
`define DSP_CLK_IO        2
`define DSP_CLK_ADC       3
`define DSP_CLK_ASY       4
`define DSP_CLK_MAIN      5
`define DSP_CLK_TOSC      6

// AXI responses
`define DSP_RESP_OKAY     2'h0
`define DSP_RESP_SLVERR   2'h2

// Power chain restart timing
`define DSP_CHAIN_NS      2000
`define DSP_CLK_NS        8
// 2000 ns at 8 ns a cycle, sized to the restart counter
`define DSP_CHAIN_CYC     9'h0FA
`define DSP_CNT_W         9

// Power states
`define DSP_ST_RUN        3'h0
`define DSP_ST_SLEEP      3'h1
`define DSP_ST_DEEP       3'h2
`define DSP_ST_CHAIN_UP   3'h3
`define DSP_ST_WAKE       3'h4

`endif

// file: dsp_power_ctrl.v
// How it works
// (R01) Deep-sleep on power-down/save with transceiver asleep
// (R02) Software waits transceiver asleep before sleeping
// (R03) Deep-sleep turns off core, chain, analog regulators
// (R04) Software finishes leakage regulator calibration first
// (R05) SRAM held in retention during deep-sleep
// (R06) Deep-sleep logic runs on slow clocks only
// (R07) Wake restores chain, then normal wake proceeds
// (R08) Converter off before deep-sleep; supply removed
// (R09) Synchronous timer 2 blocks deep-sleep entry
// (R10) No deep-sleep during on-chip debug
// (R11) Software: transceiver sleep, mode 2, sleep
// (R12) Each mode stops its documented clock domains
// (R13) Each mode accepts its documented wake sources
// (R14) Timer oscillator kept only in async timer mode
// (R15) Upper external lines wake only as level; code lets them wake in idle regardless of the level bits
// (R16) Symbol counter, transceiver wake only when awake
// (R17) Three-bit mode field codes select modes
// (R18) Sleep only with enable bit and instruction
// (R19) Recheck entry each time; leave on first wake
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dsp_map.vh"

module dsp_power_ctrl (
	// Clock and reset
	input  wire                    aclk,
	input  wire                    aresetn,
	// AXI4-Lite write address
	input  wire [3:0]              s_axi_awaddr,
	input  wire                    s_axi_awvalid,
	output reg                     s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output reg                     s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	// AXI4-Lite read address
	input  wire [3:0]              s_axi_araddr,
	input  wire                    s_axi_arvalid,
	output reg                     s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready,
	// CPU side
	input  wire                    sleep_instr,
	input  wire                    debug_active,
	output reg                     cpu_wake,
	// Transceiver state
	input  wire                    transceiver_asleep,
	// Wake sources
	input  wire [`DSP_SRC_W-1:0]   wake_src,
	// Power and clock controls
	output reg  [`DSP_CLK_W-1:0]   clock_domain_en,
	output reg                     digital_core_supply_en,
	output reg                     power_chain_en,
	output reg                     analog_supply_en,
	output reg                     sram_retention,
	output reg                     deep_sleep,
	input  wire                    power_chain_good
);

	reg [`DSP_CTRL_W-1:0]  ctrl;
	reg [`DSP_WAKE_W-1:0]  wake_cfg;
	reg [2:0]              state;
	reg [2:0]              next_state;
	reg [2:0]              mode;
	reg [`DSP_CNT_W-1:0]   chain_cnt;
	reg                    aw_hold;
	reg                    w_hold;
	reg [3:0]              aw_addr;
	reg [31:0]             w_data;
	reg [3:0]              w_strb;

	wire        sleep_en = ctrl[`DSP_CTRL_SE];
	wire [2:0]  sm_field = ctrl[`DSP_CTRL_SM_HI:`DSP_CTRL_SM_LO];
	wire        t2_async = ctrl[`DSP_CTRL_AS2];
	wire [3:0]  lvl_cfg  = wake_cfg[`DSP_LVL_HI:`DSP_LVL_LO];

	// Mode validity; codes 100 and 101 are reserved and never sleep
	reg mode_ok;
	always @* begin
		case (sm_field)
			`DSP_SM_IDLE, `DSP_SM_ADCNR, `DSP_SM_PDOWN,
			`DSP_SM_PSAVE, `DSP_SM_STBY, `DSP_SM_XSTBY:
				mode_ok = 1'b1; // R17
			default:
				mode_ok = 1'b0;
		endcase
	end

	// Deep-sleep entry, evaluated fresh at each sleep instruction
	// Debug overrides the rest so a live probe never loses power
	wire deep_ok = ((sm_field == `DSP_SM_PDOWN) ||
		(sm_field == `DSP_SM_PSAVE)) && // R01
		transceiver_asleep && // R01
		t2_async && // R09
		!debug_active; // R10

	// Clock domains that stay running per mode
	// Reads the live field; only used on the edge that enters sleep
	reg [`DSP_CLK_W-1:0] run_clk;
	always @* begin
		run_clk = {`DSP_CLK_W{1'b0}};
		case (sm_field)
			`DSP_SM_IDLE: begin
				run_clk = `DSP_CLK_ALL; // R12
				run_clk[`DSP_CLK_CPU] = 1'b0;
				run_clk[`DSP_CLK_FLASH] = 1'b0;
				run_clk[`DSP_CLK_TOSC] = t2_async; // R14
			end
			`DSP_SM_ADCNR: begin
				run_clk[`DSP_CLK_ADC] = 1'b1; // R12
				run_clk[`DSP_CLK_ASY] = 1'b1;
				run_clk[`DSP_CLK_MAIN] = 1'b1;
				run_clk[`DSP_CLK_TOSC] = t2_async; // R14
			end
			`DSP_SM_PSAVE: begin
				run_clk[`DSP_CLK_ASY] = 1'b1;
				run_clk[`DSP_CLK_TOSC] = t2_async; // R14
			end
			`DSP_SM_STBY: begin
				run_clk[`DSP_CLK_MAIN] = 1'b1; // R12
			end
			`DSP_SM_XSTBY: begin
				run_clk[`DSP_CLK_MAIN] = 1'b1;
				run_clk[`DSP_CLK_ASY] = t2_async; // R14
				run_clk[`DSP_CLK_TOSC] = t2_async;
			end
			default: begin
				run_clk = {`DSP_CLK_W{1'b0}}; // R12
			end
		endcase
		// A synchronous timer 2 keeps the main oscillator alive
		if (!t2_async && sm_field != `DSP_SM_IDLE)
			run_clk[`DSP_CLK_MAIN] = 1'b1; // R09
	end

	// Wake source gating per mode
	// Mode is latched at entry, so a mode write in sleep cannot regate; level bits and AS2 stay live
	reg [`DSP_SRC_W-1:0] allow;
	always @* begin
		allow = {`DSP_SRC_W{1'b1}};
		if (mode != `DSP_SM_IDLE)
			allow[`DSP_SRC_UPPER_HI:`DSP_SRC_UPPER_LO] = lvl_cfg; // R15
		case (mode)
			`DSP_SM_IDLE: begin
				allow[`DSP_SRC_OTHER] = 1'b1; // R13
			end
			`DSP_SM_ADCNR: begin
				allow[`DSP_SRC_OTHER] = 1'b0; // R13
				allow[`DSP_SRC_T2] = t2_async; // R14
			end
			`DSP_SM_PDOWN, `DSP_SM_STBY: begin
				allow[`DSP_SRC_T2] = 1'b0; // R13
				allow[`DSP_SRC_SPM] = 1'b0;
				allow[`DSP_SRC_ADC] = 1'b0;
				allow[`DSP_SRC_OTHER] = 1'b0;
			end
			`DSP_SM_PSAVE, `DSP_SM_XSTBY: begin
				allow[`DSP_SRC_SPM] = 1'b0; // R13
				allow[`DSP_SRC_ADC] = 1'b0;
				allow[`DSP_SRC_OTHER] = 1'b0;
			end
			default: begin
				allow = {`DSP_SRC_W{1'b0}};
			end
		endcase
		if (transceiver_asleep) begin
			allow[`DSP_SRC_SYMCNT] = 1'b0; // R16
			allow[`DSP_SRC_TRX] = 1'b0; // R16
		end
	end

	// Source enables: low 11 bits cover ints, upper lines, pcint, twi, t2 only
	wire [`DSP_SRC_W-1:0] src_en = {6'h3F, wake_cfg[10:0]};
	wire wake_hit = |(wake_src & src_en & allow);

	// Power state machine
	always @* begin
		next_state = state;
		case (state)
			`DSP_ST_RUN: begin
				if (sleep_instr && sleep_en && mode_ok) begin // R18
					if (deep_ok)
						next_state = `DSP_ST_DEEP; // R01
					else
						next_state = `DSP_ST_SLEEP;
				end
			end
			`DSP_ST_SLEEP: begin
				if (wake_hit)
					next_state = `DSP_ST_WAKE;
			end
			`DSP_ST_DEEP: begin
				if (wake_hit)
					next_state = `DSP_ST_CHAIN_UP; // R19
			end
			`DSP_ST_CHAIN_UP: begin
				// Counter and chain both report; the later one decides
				if (power_chain_good && chain_cnt == {`DSP_CNT_W{1'b0}})
					next_state = `DSP_ST_WAKE; // R07
			end
			`DSP_ST_WAKE: begin
				next_state = `DSP_ST_RUN;
			end
			default: begin
				next_state = `DSP_ST_RUN;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= `DSP_ST_RUN;
			mode <= `DSP_SM_IDLE;
			chain_cnt <= {`DSP_CNT_W{1'b0}};
			clock_domain_en <= `DSP_CLK_ALL;
			digital_core_supply_en <= 1'b1;
			power_chain_en <= 1'b1;
			analog_supply_en <= 1'b1;
			sram_retention <= 1'b0;
			deep_sleep <= 1'b0;
			cpu_wake <= 1'b0;
		end else begin
			state <= next_state;
			if (state == `DSP_ST_RUN)
				mode <= sm_field;
			if (next_state == `DSP_ST_CHAIN_UP && state == `DSP_ST_DEEP)
				chain_cnt <= `DSP_CHAIN_CYC;
			else if (chain_cnt != {`DSP_CNT_W{1'b0}})
				chain_cnt <= chain_cnt - 1'b1;
			cpu_wake <= (next_state == `DSP_ST_WAKE);
			// Regulators drop only in deep-sleep; all three come back on the same edge on wake
			digital_core_supply_en <= (next_state != `DSP_ST_DEEP); // R03
			power_chain_en <= (next_state != `DSP_ST_DEEP); // R03
			analog_supply_en <= (next_state != `DSP_ST_DEEP); // R08
			sram_retention <= (next_state == `DSP_ST_DEEP); // R05
			deep_sleep <= (next_state == `DSP_ST_DEEP); // R01
			// Clocks stay stopped until the chain is back
			case (next_state)
				`DSP_ST_SLEEP, `DSP_ST_DEEP, `DSP_ST_CHAIN_UP:
					clock_domain_en <= (state == `DSP_ST_RUN) ?
						run_clk : clock_domain_en; // R12
				default:
					clock_domain_en <= `DSP_CLK_ALL; // R07
			endcase
		end
	end

	// AXI4-Lite slave: address and data may arrive in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire do_wr   = aw_hold && w_hold && !s_axi_bvalid;
	wire [3:0] wr_addr = aw_addr;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DSP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `DSP_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			ctrl <= `DSP_CTRL_RESET;
			wake_cfg <= `DSP_WAKE_RESET;
		end else begin
			s_axi_awready <= !aw_hold && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_hold && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DSP_RESP_OKAY;
				case (wr_addr)
					`DSP_OFF_CTRL:
						if (w_strb[0])
							ctrl <= w_data[`DSP_CTRL_W-1:0];
					`DSP_OFF_WAKE: begin
						if (w_strb[0])
							wake_cfg[7:0] <= w_data[7:0];
						if (w_strb[1])
							wake_cfg[14:8] <= w_data[14:8];
					end
					`DSP_OFF_STATUS, `DSP_OFF_CLOCKS: begin
						// Read-only words: write dropped, still answered
						s_axi_bresp <= `DSP_RESP_OKAY;
					end
					default:
						s_axi_bresp <= `DSP_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `DSP_RESP_OKAY;
				case (s_axi_araddr)
					`DSP_OFF_CTRL:
						s_axi_rdata <= {27'h0, ctrl};
					`DSP_OFF_WAKE:
						s_axi_rdata <= {17'h0, wake_cfg};
					`DSP_OFF_STATUS:
						s_axi_rdata <= {24'h0, mode, deep_sleep,
							sram_retention, state};
					`DSP_OFF_CLOCKS:
						s_axi_rdata <= {25'h0, clock_domain_en};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `DSP_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // dsp_power_ctrl

// file: dsp_power_ctrl_assertions.sv
`timescale 1ns/1ps
module dsp_power_ctrl_chk (
	// Clock and reset
	input logic	aclk,
	input logic	aresetn,
	// Bus answers
	input logic	s_axi_bvalid,
	input logic	s_axi_bready,
	input logic	s_axi_rvalid,
	input logic	s_axi_rready,
	// Sleep control
	input logic	debug_active,
	input logic	transceiver_asleep,
	input logic	cpu_wake,
	input logic	deep_sleep,
	input logic	sram_retention,
	// Supplies
	input logic	digital_core_supply_en,
	input logic	power_chain_en,
	input logic	analog_supply_en,
	input logic	power_chain_good
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_deep_supply_off: assert property (deep_sleep |->
		!digital_core_supply_en && !power_chain_en && !analog_supply_en)
		else $error("supply on in deep sleep");
	a_deep_sram_kept: assert property (deep_sleep |-> sram_retention)
		else $error("no retention in deep sleep");
	a_deep_trx_asleep: assert property ($rose(deep_sleep) |->
		$past(transceiver_asleep)) else $error("deep with trx awake");
	a_deep_no_debug: assert property ($rose(deep_sleep) |->
		!$past(debug_active)) else $error("deep during debug");
	a_wake_chain_up: assert property (cpu_wake |->
		power_chain_en && power_chain_good) else $error("wake before chain");
	a_wake_not_early: assert property ($rose(power_chain_en) |->
		!cpu_wake [*8]) else $error("wake during chain restart");
	a_wake_one_pulse: assert property (cpu_wake |=> !cpu_wake)
		else $error("wake pulse too long");
	a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("bvalid dropped");
	a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid) else $error("rvalid dropped");
	c_deep: cover property ($rose(deep_sleep));
	c_chain: cover property ($rose(power_chain_en));
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // dsp_power_ctrl_chk

bind dsp_power_ctrl dsp_power_ctrl_chk chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.debug_active(debug_active), .transceiver_asleep(transceiver_asleep),
	.cpu_wake(cpu_wake), .deep_sleep(deep_sleep),
	.sram_retention(sram_retention), .power_chain_en(power_chain_en),
	.digital_core_supply_en(digital_core_supply_en),
	.analog_supply_en(analog_supply_en),
	.power_chain_good(power_chain_good));

// file: dsp_power_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module dsp_power_ctrl_tb;
	logic [3:0]	awa, ara, ws;
	logic [31:0]	wd, rd, d;
	logic [1:0]	br, rr;
	logic [16:0]	src;
	logic [6:0]	ce;
	logic	aclk, aresetn, awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
	logic	slp, dbg, wake, trx, dsl, ret, core, chain, ana, good;
	int	err_total, tests_run, i;
	logic [2:0]	md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [6:0]	ex [6] = '{7'h7C, 7'h78, 7'h00, 7'h50, 7'h20, 7'h70};
	always #4 aclk = ~aclk;
	dsp_power_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .sleep_instr(slp),
		.debug_active(dbg), .cpu_wake(wake), .transceiver_asleep(trx),
		.wake_src(src), .clock_domain_en(ce),
		.digital_core_supply_en(core), .power_chain_en(chain),
		.analog_supply_en(ana), .sram_retention(ret), .deep_sleep(dsl),
		.power_chain_good(good));
	dsp_chain_model chain_u (.aclk(aclk), .aresetn(aresetn),
		.power_chain_en(chain), .power_chain_good(good));
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input [3:0] a, input [31:0] v);
		int n;
		@(posedge aclk);
		awa <= a; wd <= v; ws <= 4'hF; awv <= 1; wv <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awv && awr) awv <= 0;
			if (wv && wrd) wv <= 0;
			if (bv && bry) break;
			if (bv) bry <= 1;
		end
		bry <= 0;
		`CHK("bresp", 2'h0, br)
		if (n == 40) begin err_total++; complete_run; end
	endtask
	task automatic rdr(input [3:0] a, input [1:0] er);
		int n;
		@(posedge aclk);
		ara <= a; arv <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arv && arr) arv <= 0;
			if (rv && rry) break;
			if (rv) rry <= 1;
		end
		d = rd;
		rry <= 0;
		`CHK("rresp", er, rr)
		if (n == 40) begin err_total++; complete_run; end
	endtask
	// Software order: enable bit and mode first, then the instruction;
	// no converter, trim or fast clock is left running by then
	task automatic go_sleep(input [2:0] m, input as2);
		wr(4'h0, {27'h0, as2, m, 1'b1});
		@(posedge aclk); slp <= 1;
		@(posedge aclk); slp <= 0;
		@(posedge aclk); #1;
	endtask
	task automatic wake_by(input [16:0] s, input int lim);
		int n;
		@(posedge aclk); src <= s;
		for (n = 0; n < lim && wake !== 1'b1; n++) @(posedge aclk);
		src <= '0;
		`CHK("cpu_wake", 1'b1, wake)
		if (wake !== 1'b1) complete_run;
	endtask
	task automatic t_modes;
		for (i = 0; i < 6; i++) begin
			go_sleep(md[i], 1'b1);
			`CHK("clocks", ex[i], ce)
			wake_by(17'h00200, 8);
		end
	endtask
	task automatic t_filter;
		go_sleep(3'h2, 1'b1);
		@(posedge aclk); src <= 17'h04410;
		repeat (8) @(posedge aclk);
		#1;
		`CHK("no wake", 7'h00, ce)
		wake_by(17'h00200, 8);
		wr(4'h4, 32'h0E10);
		go_sleep(3'h2, 1'b1);
		wake_by(17'h00010, 8);
		go_sleep(3'h0, 1'b1);
		wake_by(17'h04000, 8);
	endtask
	// Deep-sleep blocked by an awake transceiver, then by debug, then by a synchronous timer 2
	task automatic t_block;
		for (i = 0; i < 3; i++) begin
			@(posedge aclk); trx <= i != 0; dbg <= i == 1;
			go_sleep(3'h2, i != 2);
			`CHK("no deep", 1'b0, dsl)
			wake_by(17'h00200, 8);
			dbg <= 0;
		end
	endtask
	task automatic t_deep;
		go_sleep(3'h3, 1'b1);
		`CHK("deep", 5'h18, {dsl, ret, core, chain, ana})
		rdr(4'h8, 2'h0);
		`CHK("status", 1'b1, d[4])
		@(posedge aclk); src <= 17'h18000;
		repeat (8) @(posedge aclk);
		#1;
		`CHK("held", 1'b1, dsl)
		wake_by(17'h00200, 400);
		@(posedge aclk); #1;
		`CHK("up", 10'h3FF, {ce, core, chain, ana})
	endtask
	initial begin
		{aclk, aresetn, awv, wv, bry, arv, rry, slp, dbg, trx} = '0;
		{awa, ara, ws, wd, src} = '0;
		err_total = 0;
		tests_run = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		#1;
		`CHK("reset", 10'h3FF, {ce, core, chain, ana})
		rdr(4'hC, 2'h0);
		`CHK("clock word", 32'h7F, d)
		rdr(4'h2, 2'h2);
		`CHK("unmapped", 32'h0, d)
		wr(4'h4, 32'h0610);
		t_modes;
		t_filter;
		t_block;
		t_deep;
		complete_run;
	end
endmodule // dsp_power_ctrl_tb
